// file: test_utmi_shared_data_bus.sv
/*
 * Self-checking bench for the shared data port with a link model.
 * Assumes a short full-speed byte time (FSB clocks) to keep runs brief.
 */
`timescale 1ns/10ps
module test_utmi_shared_data_bus;
    localparam int FSB = 4;
    logic       i_clk = 1'b0, i_rst_b = 1'b0, sel = 1'b0, go = 1'b0;
    logic       rx_sop = 1'b0, rx_eop = 1'b0, rx_valid = 1'b0, stuff8 = 1'b0;
    logic       tx_ready = 1'b1, txvalid, txready, rxactive, rxvalid, oe, rx_ready, tx_valid;
    logic [7:0] rx_byte = 8'h00, first = 8'h00, link_data, phy_data, tx_byte, rx_last;
    logic [3:0] count = 4'h0, rx_cnt;
    logic [7:0] txq[$];
    int n_errors = 0, n_compared = 0, cyc = 0, last_tr = -100, close_fs = 0, near_hs = 0;
    int tr_n = 0, oe_bad = 0, rises = 0, falls = 0, rxv_run = 0, prev_txv = 0, prev_act = 0;
    always #10 i_clk = ~i_clk;
    utmi_shared_data_bus #(.FS_BYTE(FSB)) DUT (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .o_phy_clock_out(), .i_txvalid(txvalid), .i_xcvr_sel(sel), .i_data(link_data),
        .o_data(phy_data), .o_data_oe(oe), .o_txready(txready), .o_rxactive(rxactive),
        .o_rxvalid(rxvalid), .i_rx_sop(rx_sop), .i_rx_eop(rx_eop), .i_rx_valid(rx_valid),
        .i_rx_byte(rx_byte), .o_rx_ready(rx_ready), .i_rx_stuff8(stuff8),
        .o_tx_valid(tx_valid), .o_tx_byte(tx_byte), .i_tx_ready(tx_ready));
    utmi_link_model link (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_go(go), .i_count(count),
        .i_first(first), .i_txready(txready), .i_rxvalid(rxvalid), .i_bus(phy_data),
        .o_txvalid(txvalid), .o_data(link_data), .o_rx_cnt(rx_cnt), .o_rx_last(rx_last));
    // -------------------------------------------------------------
    // monitors, sampled mid-cycle where registered outputs are settled
    // -------------------------------------------------------------
    always @(negedge i_clk) begin
        cyc++;
        if (i_rst_b && txready) begin
            if (sel && cyc - last_tr < FSB) close_fs++;
            if (!sel && cyc - last_tr == 1) near_hs++;
            last_tr = cyc;
            tr_n++;
        end
        if (i_rst_b && cyc > 5 && oe !== !prev_txv) oe_bad++;
        if (rxactive === 1'b1 && !prev_act) rises++;
        if (rxactive === 1'b0 && prev_act) falls++;
        rxv_run = (rxvalid === 1'b1) ? rxv_run + 1 : 0;
        if (sel && rxv_run > 1) close_fs++;
        if (tx_valid === 1'b1 && tx_ready) txq.push_back(tx_byte);
        prev_txv = txvalid;
        prev_act = (rxactive === 1'b1);
    end
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic complete_run;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    task automatic give_up;
        n_errors++;
        complete_run();
    endtask : give_up
    // burst of n bytes from the link, optionally with the serial engine stalling
    task automatic tx_burst(input logic s, input int n, input logic [7:0] b, input bit stall);
        int k;
        txq.delete();
        tr_n = 0;
        close_fs = 0;
        near_hs = 0;
        @(posedge i_clk);
        sel <= s;
        first <= b;
        count <= 4'(n);
        go <= 1'b1;
        tx_ready <= !stall;
        @(posedge i_clk);
        go <= 1'b0;
        if (stall) begin
            repeat (12 * FSB) @(posedge i_clk);
            tx_ready <= 1'b1;
        end
        @(negedge i_clk);
        for (k = 0; k < 2000 && txvalid; k++) @(negedge i_clk);
        if (txvalid) give_up();
        repeat (8) @(posedge i_clk);
    endtask : tx_burst
    task automatic tx_fs_stall;
        int i;
        tx_burst(1'b1, 5, 8'hA0, 1'b1);
        check("fs txready count", 8'(tr_n), 8'h05);
        check("fs close pulses", 8'(close_fs), 8'h00);
        check("fs bytes out", 8'(txq.size()), 8'h05);
        for (i = 0; i < txq.size(); i++) check("fs byte", txq[i], 8'hA0 + 8'(i));
    endtask : tx_fs_stall
    task automatic tx_hs;
        tx_burst(1'b0, 6, 8'h30, 1'b0);
        check("hs back to back", 8'(near_hs > 0), 8'h01);
        check("hs first byte", txq.size() > 0 ? txq[0] : 8'hFF, 8'h30);
        check("hs bytes out", 8'(txq.size()), 8'h06);
        check("hs last byte", txq.size() > 5 ? txq[5] : 8'hFF, 8'h35);
        check("bus direction", 8'(oe_bad), 8'h00);
    endtask : tx_hs
    // one packet of four bytes from the serial engine
    task automatic rx_pkt(input logic s, input bit skip);
        int i, k;
        logic [3:0] c0;
        c0 = rx_cnt;
        rises = 0;
        falls = 0;
        close_fs = 0;
        @(posedge i_clk);
        sel <= s;
        rx_sop <= 1'b1;
        @(posedge i_clk);
        rx_sop <= 1'b0;
        for (i = 0; i < 4; i++) begin
            rx_valid <= 1'b1;
            rx_byte <= 8'h51 + 8'(i);
            stuff8 <= skip && i == 2;
            @(negedge i_clk);
            for (k = 0; k < 400 && !rx_ready; k++) @(negedge i_clk);
            if (!rx_ready) give_up();
            @(posedge i_clk);
            stuff8 <= 1'b0;
        end
        rx_valid <= 1'b0;
        rx_eop <= 1'b1;
        @(posedge i_clk);
        rx_eop <= 1'b0;
        for (k = 0; k < 800 && rxactive !== 1'b0; k++) @(posedge i_clk);
        if (rxactive !== 1'b0) give_up();
        repeat (3) @(posedge i_clk);
        check("rx bytes", 8'(rx_cnt - c0), 8'h04);
        check("rx last", rx_last, 8'h54);
        check("rxactive rises", 8'(rises), 8'h01);
        check("rxactive falls", 8'(falls), 8'h01);
        check("fs rxvalid width", 8'(close_fs), 8'h00);
    endtask : rx_pkt
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        tx_fs_stall();
        tx_hs();
        rx_pkt(1'b0, 1'b0);
        rx_pkt(1'b1, 1'b1);
        complete_run();
    end
    initial begin
        repeat (50000) @(posedge i_clk);
        give_up();
    end
endmodule : test_utmi_shared_data_bus

// file: utmi_bus_pkg.sv
/*
 * Constants for the shared 8-bit parallel data port of a USB 2.0
 * transceiver: widths, byte timing counts and reset values.
 * Assumes the port clock is the 60 MHz clock the transceiver drives out.
 */
package utmi_bus_pkg;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned CLK_MHZ       = 60;
    // full-speed byte time in port clocks
    localparam int unsigned FS_BYTE_CLKS  = 40;
    // high-speed byte time: one byte per clock
    localparam int unsigned HS_BYTE_CLKS  = 1;
    localparam int unsigned CNT_W         = 6;
    // removed stuffed bits that cost one byte time
    localparam int unsigned STUFF_SKIP    = 8;
    localparam logic [7:0]  DATA_RST      = 8'h00;
    // transceiver select codes
    localparam logic        SEL_HS        = 1'b0;
    localparam logic        SEL_FS        = 1'b1;
endpackage : utmi_bus_pkg

// file: utmi_link_model.sv
/*
 * Link-side partner of the parallel port: sends a burst of bytes on the
 * shared bus and captures the bytes that the transceiver presents.
 * Assumes the block's port clock and its active-low asynchronous reset.
 */
`timescale 1ns/10ps
module utmi_link_model (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    // burst control from the bench
    input  wire logic       i_go,
    input  wire logic [3:0] i_count,
    input  wire logic [7:0] i_first,
    // port signals
    input  wire logic       i_txready,
    input  wire logic       i_rxvalid,
    input  wire logic [7:0] i_bus,
    output logic            o_txvalid,
    output logic [7:0]      o_data,
    // results
    output logic [3:0]      o_rx_cnt,
    output logic [7:0]      o_rx_last
);
    logic [3:0] left_r;
    // -------------------------------------------------------------
    // transmit side
    // -------------------------------------------------------------
    // a byte stays put until a txready is seen; a released bus shows the
    // inverse of the last byte so a stale value never looks valid
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_txvalid <= 1'b0;
            o_data    <= 8'h00;
            left_r    <= 4'h0;
        end else if (i_go) begin
            o_txvalid <= 1'b1;
            o_data    <= i_first;
            left_r    <= i_count;
        end else if (o_txvalid && i_txready) begin
            left_r    <= left_r - 4'h1;
            o_txvalid <= (left_r != 4'h1);
            o_data    <= (left_r == 4'h1) ? ~o_data : o_data + 8'h01;
        end
    end
    // -------------------------------------------------------------
    // receive side
    // -------------------------------------------------------------
    // capture the bus at the edge that samples rxvalid high
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rx_cnt  <= 4'h0;
            o_rx_last <= 8'h00;
        end else if (i_rxvalid && !o_txvalid) begin
            o_rx_cnt  <= o_rx_cnt + 4'h1;
            o_rx_last <= i_bus;
        end
    end
endmodule : utmi_link_model

// file: utmi_shared_data_bus.sv
/*
 * Link-side parallel port of a USB 2.0 transceiver: one shared 8-bit
 * data bus, transmit handshake and receive framing at HS or FS byte rate.
 * Assumes the serial engine delivers received bytes on a valid/ready
 * stream with packet start/end strobes, and takes transmit bytes likewise.
 * Link pins (TXVALID, select) come from logic on the same port clock.
 */
`timescale 1ns/10ps
// How it works
// - free-running port clock, all on rising edge
// - txvalid high: link drives bus (transceiver releases it one clock later)
// - txvalid low: transceiver drives bus (from one clock later)
// - FS: txready one clock per byte
// - rxactive high whole packet, no glitches
// - rxvalid changes whenever byte assembled (here only on a byte tick, not when skipped or while txvalid high)
// - FS: rxvalid one clock per byte
// - select picks HS or FS timing
// - FS byte time is 40 clocks
// - eight unstuffed bits skip one byte
module utmi_shared_data_bus #(
    parameter int unsigned FS_BYTE = utmi_bus_pkg::FS_BYTE_CLKS
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    // port clock driven out to the link
    output logic            o_phy_clock_out,
    // link control
    input  wire logic       i_txvalid,
    input  wire logic       i_xcvr_sel,
    // shared data bus
    input  wire logic [7:0] i_data,
    output logic [7:0]      o_data,
    output logic            o_data_oe,
    // handshakes to the link
    output logic            o_txready,
    output logic            o_rxactive,
    output logic            o_rxvalid,
    // receive stream from the serial engine
    input  wire logic       i_rx_sop,
    input  wire logic       i_rx_eop,
    input  wire logic       i_rx_valid,
    input  wire logic [7:0] i_rx_byte,
    output logic            o_rx_ready,
    input  wire logic       i_rx_stuff8,
    // transmit stream to the serial engine
    output logic            o_tx_valid,
    output logic [7:0]      o_tx_byte,
    input  wire logic       i_tx_ready
);
    typedef enum logic [1:0] {RX_IDLE, RX_PKT, RX_DRAIN} rx_state_t;

    localparam logic [5:0] FS_LAST = 6'(FS_BYTE - 1);

    rx_state_t  rx_st_r;
    logic [5:0] tick_cnt_r;
    logic       byte_tick;
    logic       buf_valid;
    logic [7:0] buf_data;
    logic       buf_pop;
    logic       skip_r;
    logic       tx_take;
    logic       tx_cap_ready;
    logic       tx_room;
    logic [5:0] tr_gap_r;
    logic [5:0] rv_gap_r;

    // ----------------------------------------------------------------
    // port clock and byte-time divider
    // ----------------------------------------------------------------
    // the port clock is the block clock itself; a forwarding flop
    // would halve it, so it is passed through as the free-running clock
    assign o_phy_clock_out = i_clk;

    // byte tick: every clock in HS, one clock in 40 in FS
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tick_cnt_r <= 6'd0;
        end else if (i_xcvr_sel == utmi_bus_pkg::SEL_HS || tick_cnt_r == FS_LAST) begin
            tick_cnt_r <= 6'd0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 6'd1;
        end
    end
    assign byte_tick = (i_xcvr_sel == utmi_bus_pkg::SEL_HS) || (tick_cnt_r == FS_LAST);

    // ----------------------------------------------------------------
    // transmit path
    // ----------------------------------------------------------------
    // the byte is taken on the edge that samples txready high, the same
    // edge on which the link counts it consumed; taking it a cycle earlier
    // would take it twice in HS, where the link has not yet moved on
    assign tx_take = o_txready && i_txvalid;

    // room in the buffer at the next edge, read from its two flags
    assign tx_room = !o_tx_valid || i_tx_ready || (tx_cap_ready && !tx_take);

    // txready is raised one cycle ahead of the taking edge, once per tick
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_txready <= 1'b0;
        end else begin
            o_txready <= i_txvalid && byte_tick && tx_room;
        end
    end

    // captured byte goes to the serial engine; stall blocks txready
    utmi_skid_buf #(.WIDTH(utmi_bus_pkg::DATA_W)) u_tx_buf (
        .i_clk       (i_clk),
        .i_rst_b     (i_rst_b),
        .i_in_valid  (tx_take),
        .i_in_data   (i_data),
        .o_in_ready  (tx_cap_ready),
        .o_out_valid (o_tx_valid),
        .o_out_data  (o_tx_byte),
        .i_out_ready (i_tx_ready)
    );

    // ----------------------------------------------------------------
    // receive path
    // ----------------------------------------------------------------
    // a two-entry buffer absorbs bytes while the byte tick is not due
    utmi_skid_buf #(.WIDTH(utmi_bus_pkg::DATA_W)) u_rx_buf (
        .i_clk       (i_clk),
        .i_rst_b     (i_rst_b),
        .i_in_valid  (i_rx_valid && rx_st_r == RX_PKT),
        .i_in_data   (i_rx_byte),
        .o_in_ready  (o_rx_ready),
        .o_out_valid (buf_valid),
        .o_out_data  (buf_data),
        .i_out_ready (buf_pop)
    );

    // a byte leaves only on a tick and never in a skipped byte time
    assign buf_pop = byte_tick && buf_valid && !skip_r && !i_txvalid;

    // skip request from the unstuffer, held until the next tick
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            skip_r <= 1'b0;
        end else if (i_rx_stuff8) begin
            skip_r <= 1'b1;
        end else if (byte_tick) begin
            skip_r <= 1'b0;
        end
    end

    // packet framing: active from start strobe until end and drained
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_st_r <= RX_IDLE;
        end else begin
            case (rx_st_r)
                RX_IDLE: begin
                    if (i_rx_sop) begin
                        rx_st_r <= RX_PKT;
                    end
                end
                RX_PKT: begin
                    if (i_rx_eop) begin
                        rx_st_r <= RX_DRAIN;
                    end
                end
                RX_DRAIN: begin
                    if (!buf_valid) begin
                        rx_st_r <= RX_IDLE;
                    end
                end
                default: begin
                    rx_st_r <= RX_IDLE;
                end
            endcase
        end
    end

    // rxactive held steady over the whole packet
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rxactive <= 1'b0;
        end else begin
            o_rxactive <= (rx_st_r != RX_IDLE);
        end
    end

    // rxvalid one clock per byte; data stays for the byte time
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rxvalid <= 1'b0;
            o_data    <= utmi_bus_pkg::DATA_RST;
        end else begin
            o_rxvalid <= buf_pop;
            if (buf_pop) begin
                o_data <= buf_data;
            end
        end
    end

    // bus released from the clock after txvalid rises until the clock after it falls
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_data_oe <= 1'b0;
        end else begin
            o_data_oe <= !i_txvalid;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    // clocks since the last txready and rxvalid pulse; they saturate so a
    // long idle never wraps round into a false short gap
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tr_gap_r <= 6'h3F;
        end else if (o_txready) begin
            tr_gap_r <= 6'h00;
        end else if (tr_gap_r != 6'h3F) begin
            tr_gap_r <= tr_gap_r + 6'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rv_gap_r <= 6'h3F;
        end else if (o_rxvalid) begin
            rv_gap_r <= 6'h00;
        end else if (rv_gap_r != 6'h3F) begin
            rv_gap_r <= rv_gap_r + 6'h01;
        end
    end

    sequence s_fs_pulse;
        o_txready ##1 !o_txready;
    endsequence

    a_fs_txready_single: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (o_txready && i_xcvr_sel == utmi_bus_pkg::SEL_FS && $stable(i_xcvr_sel))
        |-> s_fs_pulse and (tr_gap_r >= FS_LAST))
        else $error("txready pulse too wide in full speed");

    a_fs_rxvalid_single: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (o_rxvalid && i_xcvr_sel == utmi_bus_pkg::SEL_FS && $stable(i_xcvr_sel))
        |-> (rv_gap_r >= FS_LAST) ##1 !o_rxvalid)
        else $error("rxvalid pulse too wide in full speed");

    a_bus_release: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_txvalid |=> !o_data_oe)
        else $error("bus driven during transmit");

    a_bus_drive_rx: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !i_txvalid |=> o_data_oe)
        else $error("bus not driven during receive");

    a_txready_cause: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_txready |-> $past(i_txvalid))
        else $error("txready without txvalid");

    a_rxactive_start: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (rx_st_r == RX_IDLE && i_rx_sop) |=> ##1 o_rxactive)
        else $error("rxactive missed packet start");

    a_rxvalid_framed: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_rxvalid |-> o_rxactive || $past(o_rxactive))
        else $error("rxvalid outside packet");

    a_hs_every_clock: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_xcvr_sel == utmi_bus_pkg::SEL_HS && i_txvalid && i_tx_ready) |=> o_txready)
        else $error("high speed byte not taken");

    a_fs_spacing: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_xcvr_sel == utmi_bus_pkg::SEL_FS && tick_cnt_r == FS_LAST) |=> tick_cnt_r == 6'd0)
        else $error("byte time length wrong");

    a_skip_blocks: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (skip_r && byte_tick) |=> !o_rxvalid)
        else $error("rxvalid during skipped byte");
endmodule : utmi_shared_data_bus

// file: utmi_skid_buf.sv
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/10ps
module utmi_skid_buf #(
    parameter int unsigned WIDTH = 8
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    // fill side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // drain side
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    logic [WIDTH-1:0] mem_r [2];
    logic             wp_r;
    logic             rp_r;
    logic [1:0]       cnt_r;
    logic             push;
    logic             pop;

    // full and empty come straight from the occupancy count
    assign o_in_ready  = (cnt_r != 2'd2);
    assign o_out_valid = (cnt_r != 2'd0);
    assign o_out_data  = mem_r[rp_r];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    // storage
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_r[wp_r] <= i_in_data;
        end
    end

    // pointers and count
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'd0;
        end else begin
            if (push) begin
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : utmi_skid_buf
